// ---- core/asp_pkg.sv ----
package asp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock periods.
    localparam int unsigned SYS_PERIOD_NS  = 5;
    localparam int unsigned LINK_PERIOD_NS = 160;

    ////////////////////////////////////////////////////////////////////////////
    // Times as printed, in their own units.
    localparam real T_CONV_FAST_MS   = 12.5;
    localparam real T_CONV_SLOW_MS   = 100.0;
    localparam real T_STBY_ACT_US    = 20.0;
    localparam real T_EXIT_FAST_MS   = 52.51;
    localparam real T_EXIT_SLOW_MS   = 401.8;
    localparam real T_WAKE_US        = 8.0;
    localparam real T_POWER_DOWN_N_US        = 30.0;
    localparam real T_PWRUP_US       = 10.0;
    localparam real T_DSS_FAST_MS    = 12.44;
    localparam real T_DSS_SLOW_MS    = 99.94;
    localparam real T_SCLK_HALF_US   = 1.0;

    ////////////////////////////////////////////////////////////////////////////
    // Device side counts, on the link clock.
    localparam int unsigned CONV_FAST_CYC =
        int'($ceil(T_CONV_FAST_MS * 1.0e6 / LINK_PERIOD_NS));
    localparam int unsigned CONV_SLOW_CYC =
        int'($ceil(T_CONV_SLOW_MS * 1.0e6 / LINK_PERIOD_NS));
    localparam int unsigned STBY_ACT_CYC  =
        int'($ceil(T_STBY_ACT_US * 1.0e3 / LINK_PERIOD_NS));
    localparam int unsigned EXIT_FAST_CYC =
        int'($ceil(T_EXIT_FAST_MS * 1.0e6 / LINK_PERIOD_NS));
    localparam int unsigned EXIT_SLOW_CYC =
        int'($ceil(T_EXIT_SLOW_MS * 1.0e6 / LINK_PERIOD_NS));
    localparam int unsigned WAKE_CYC      =
        int'($ceil(T_WAKE_US * 1.0e3 / LINK_PERIOD_NS));

    ////////////////////////////////////////////////////////////////////////////
    // Host side counts, on the system clock.
    localparam int unsigned POWER_DOWN_N_CYC      =
        int'($ceil(T_POWER_DOWN_N_US * 1.0e3 / SYS_PERIOD_NS));
    localparam int unsigned PWRUP_CYC     =
        int'($ceil(T_PWRUP_US * 1.0e3 / SYS_PERIOD_NS));
    localparam int unsigned STBY_HOLD_CYC =
        int'($ceil(T_STBY_ACT_US * 1.0e3 / SYS_PERIOD_NS));
    localparam int unsigned DSS_FAST_CYC  =
        int'($floor(T_DSS_FAST_MS * 1.0e6 / SYS_PERIOD_NS));
    localparam int unsigned DSS_SLOW_CYC  =
        int'($floor(T_DSS_SLOW_MS * 1.0e6 / SYS_PERIOD_NS));
    localparam int unsigned SCLK_HALF_CYC =
        int'($ceil(T_SCLK_HALF_US * 1.0e3 / SYS_PERIOD_NS));

    ////////////////////////////////////////////////////////////////////////////
    // Widths and framing.
    localparam int DATA_W     = 18;
    localparam int SCLK_TOTAL = 24;
    localparam int BIT_W      = 5;
    localparam int CNT_W      = 25;
    localparam int FIFO_DEPTH = 32;

    typedef enum logic [2:0] {
        DEV_OFF,
        DEV_WAKE,
        DEV_RUN,
        DEV_STBY,
        DEV_EXIT
    } asp_dev_state_t;

    typedef enum logic [2:0] {
        HST_PD,
        HST_IDLE,
        HST_HI,
        HST_LO,
        HST_STBY
    } asp_hst_state_t;

endpackage

// ---- core/asp_link_if.sv ----
interface asp_link_if (
    input wire logic clk_link
);
    logic sclk;
    logic power_down_n;
    logic ready_data_out;

    modport dev (
        input  clk_link,
        input  sclk,
        input  power_down_n,
        output ready_data_out
    );

    modport host (
        output sclk,
        output power_down_n,
        input  ready_data_out
    );
endinterface

// ---- core/asp_dev_end.sv ----
// How it works
// R1: Shift clock held high after ready requests standby.
// R2: Standby accepted anywhere within a readback.
// R3: Standby turns analog off, oscillator keeps running.
// R4: Host raises clock within rate's window.
// R5: Standby after clock high twenty microseconds.
// R6: Output held high through all of standby.
// R7: Clock low ends standby, starts wake-up.
// R8: First result after standby is valid.
// R9: Ready after standby exit at fixed time.
// R10: Power-down held low ten microseconds past supply.
// R11: Power-down low shuts whole converter off.
// R12: Power-down resets every state machine.
// R13: Power-down accepted mid readback.
// R14: Power-down pulse thirty microseconds, wake eight.
// R15: Output falling low marks a new result.
// R16: Rate input low slow, high fast.
// R17: Result shifts out MSB first on rises.
// R18: In power-down output high, clock ignored.
module asp_dev_end #(
    parameter int unsigned CONV_FAST_CYC = asp_pkg::CONV_FAST_CYC,
    parameter int unsigned CONV_SLOW_CYC = asp_pkg::CONV_SLOW_CYC,
    parameter int unsigned EXIT_FAST_CYC = asp_pkg::EXIT_FAST_CYC,
    parameter int unsigned EXIT_SLOW_CYC = asp_pkg::EXIT_SLOW_CYC
) (
    asp_link_if.dev                          link,
    input  wire logic                        resetn,
    input  wire logic                        rate_fast,
    input  wire logic [asp_pkg::DATA_W-1:0]  sample_in,
    output logic                             analog_on,
    output logic                             converter_on,
    output logic                             standby_on
);
    localparam int CW = asp_pkg::CNT_W;
    localparam int DW = asp_pkg::DATA_W;

    logic                    sclk_m_r;
    logic                    sclk_s_r;
    logic                    sclk_d_r;
    logic                    pdn_m_r;
    logic                    pdn_s_r;
    logic                    rate_m_r;
    logic                    rate_s_r;
    logic [DW-1:0]           samp_m_r;
    logic [DW-1:0]           samp_s_r;
    asp_pkg::asp_dev_state_t state_r;
    asp_pkg::asp_dev_state_t state_nxt;
    logic [CW-1:0]           tcnt_r;
    logic [CW-1:0]           conv_cnt_r;
    logic [CW-1:0]           hi_cnt_r;
    logic [CW-1:0]           conv_last;
    logic [CW-1:0]           exit_last;
    logic                    armed_r;
    logic [DW-1:0]           shift_r;
    logic                    out_r;
    logic                    sclk_rise;
    logic                    wake_done;
    logic                    exit_done;
    logic                    conv_done;
    logic                    stby_hit;
    logic                    new_data;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers. The sample bus is taken as quasi-static: it is only
    // looked at on the cycle a result is latched.
    always_ff @(posedge link.clk_link or negedge resetn) begin
        if (!resetn) begin
            sclk_m_r <= 1'b0;
            sclk_s_r <= 1'b0;
            sclk_d_r <= 1'b0;
            pdn_m_r  <= 1'b0;
            pdn_s_r  <= 1'b0;
            rate_m_r <= 1'b0;
            rate_s_r <= 1'b0;
            samp_m_r <= '0;
            samp_s_r <= '0;
        end else begin
            sclk_m_r <= link.sclk;
            sclk_s_r <= sclk_m_r;
            sclk_d_r <= sclk_s_r;
            pdn_m_r  <= link.power_down_n;
            pdn_s_r  <= pdn_m_r;
            rate_m_r <= rate_fast;
            rate_s_r <= rate_m_r;
            samp_m_r <= sample_in;
            samp_s_r <= samp_m_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoded events.
    assign sclk_rise = sclk_s_r & ~sclk_d_r;
    assign conv_last = rate_s_r ? CW'(CONV_FAST_CYC - 1)
                                : CW'(CONV_SLOW_CYC - 1); // R16
    assign exit_last = rate_s_r ? CW'(EXIT_FAST_CYC - 1)
                                : CW'(EXIT_SLOW_CYC - 1); // R9
    assign wake_done = (state_r == asp_pkg::DEV_WAKE)
                       && (tcnt_r == CW'(asp_pkg::WAKE_CYC - 1)); // R14
    assign exit_done = (state_r == asp_pkg::DEV_EXIT)
                       && (tcnt_r == exit_last); // R9
    assign conv_done = (state_r == asp_pkg::DEV_RUN)
                       && (conv_cnt_r == conv_last);
    // A readback clock is far shorter than the activation time, so a high
    // level that survives the full count can only be a standby request.
    assign stby_hit  = armed_r && sclk_s_r
                       && (hi_cnt_r == CW'(asp_pkg::STBY_ACT_CYC - 1)); // R5
    assign new_data  = conv_done || exit_done;

    ////////////////////////////////////////////////////////////////////////////
    // Mode sequencer.
    always_comb begin
        state_nxt = state_r;
        if (!pdn_s_r) begin
            state_nxt = asp_pkg::DEV_OFF; // R11
        end else begin
            unique case (state_r)
                asp_pkg::DEV_OFF: begin
                    state_nxt = asp_pkg::DEV_WAKE;
                end
                asp_pkg::DEV_WAKE: begin
                    if (wake_done) begin
                        state_nxt = asp_pkg::DEV_RUN; // R14
                    end
                end
                asp_pkg::DEV_RUN: begin
                    if (stby_hit) begin
                        state_nxt = asp_pkg::DEV_STBY; // R1
                    end
                end
                asp_pkg::DEV_STBY: begin
                    if (!sclk_s_r) begin
                        state_nxt = asp_pkg::DEV_EXIT; // R7
                    end
                end
                asp_pkg::DEV_EXIT: begin
                    if (exit_done) begin
                        state_nxt = asp_pkg::DEV_RUN;
                    end
                end
                default: begin
                    state_nxt = asp_pkg::DEV_OFF;
                end
            endcase
        end
    end

    // Power-down low forces the sequencer to its initial state from anywhere,
    // including part way through a readback.
    always_ff @(posedge link.clk_link or negedge resetn) begin
        if (!resetn) begin
            state_r <= asp_pkg::DEV_OFF;
        end else begin
            state_r <= state_nxt; // R12 R13
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timers.
    always_ff @(posedge link.clk_link or negedge resetn) begin
        if (!resetn) begin
            tcnt_r <= '0;
        end else if (state_nxt != state_r) begin
            tcnt_r <= '0;
        end else if (state_r == asp_pkg::DEV_WAKE || state_r == asp_pkg::DEV_EXIT) begin
            tcnt_r <= tcnt_r + CW'(1);
        end
    end

    always_ff @(posedge link.clk_link or negedge resetn) begin
        if (!resetn) begin
            conv_cnt_r <= '0;
        end else if (state_r != asp_pkg::DEV_RUN || new_data) begin
            conv_cnt_r <= '0;
        end else begin
            conv_cnt_r <= conv_cnt_r + CW'(1);
        end
    end

    // Any low level restarts the count, so only a continuous high qualifies.
    always_ff @(posedge link.clk_link or negedge resetn) begin
        if (!resetn) begin
            hi_cnt_r <= '0;
        end else if (state_r == asp_pkg::DEV_RUN && armed_r && sclk_s_r
                     && !stby_hit) begin
            hi_cnt_r <= hi_cnt_r + CW'(1); // R5 R2
        end else begin
            hi_cnt_r <= '0;
        end
    end

    // Standby may only follow a ready indication.
    always_ff @(posedge link.clk_link or negedge resetn) begin
        if (!resetn) begin
            armed_r <= 1'b0;
        end else if (state_r == asp_pkg::DEV_OFF || state_nxt == asp_pkg::DEV_STBY) begin
            armed_r <= 1'b0; // R12
        end else if (new_data) begin
            armed_r <= 1'b1; // R1
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ready and data output. Ones are shifted in behind the result, so extra
    // clocks after the last bit leave the line high for polling.
    always_ff @(posedge link.clk_link or negedge resetn) begin
        if (!resetn) begin
            out_r   <= 1'b1;
            shift_r <= '1;
        end else if (!pdn_s_r) begin
            out_r   <= 1'b1; // R18
            shift_r <= '1;
        end else if (new_data) begin
            out_r   <= 1'b0; // R15 R8
            shift_r <= samp_s_r;
        end else if (state_r != asp_pkg::DEV_RUN || state_nxt != asp_pkg::DEV_RUN) begin
            out_r   <= 1'b1; // R6
            shift_r <= '1;
        end else if (sclk_rise) begin
            out_r   <= shift_r[DW-1]; // R17
            shift_r <= {shift_r[DW-2:0], 1'b1};
        end
    end

    assign link.ready_data_out = out_r;

    ////////////////////////////////////////////////////////////////////////////
    // Power status outputs.
    always_ff @(posedge link.clk_link or negedge resetn) begin
        if (!resetn) begin
            analog_on    <= 1'b0;
            converter_on <= 1'b0;
            standby_on   <= 1'b0;
        end else begin
            analog_on    <= (state_nxt == asp_pkg::DEV_RUN)
                            || (state_nxt == asp_pkg::DEV_EXIT)
                            || (state_nxt == asp_pkg::DEV_WAKE); // R3
            converter_on <= (state_nxt != asp_pkg::DEV_OFF); // R11
            standby_on   <= (state_nxt == asp_pkg::DEV_STBY); // R3
        end
    end

endmodule

// ---- core/asp_host_end.sv ----
module asp_fifo #(
    parameter int W     = 18,
    parameter int DEPTH = 32
) (
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0]   cnt_r;
    logic [AW:0]   cnt_nxt;
    logic          wr;
    logic          rd;
    logic [AW-1:0] head_nxt;

    assign wr       = in_valid & in_ready;
    assign rd       = out_valid & out_ready;
    assign cnt_nxt  = cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
    assign head_nxt = rd_ptr_r + AW'(rd);

    always_ff @(posedge clk_sys) begin
        if (wr) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_r  <= '0;
            rd_ptr_r  <= '0;
            cnt_r     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            wr_ptr_r  <= wr_ptr_r + AW'(wr);
            rd_ptr_r  <= rd_ptr_r + AW'(rd);
            cnt_r     <= cnt_nxt;
            in_ready  <= (cnt_nxt != (AW+1)'(DEPTH));
            out_valid <= (cnt_nxt != '0);
            // The head is registered, so a word landing in an empty queue bypasses the memory.
            out_data  <= (wr && wr_ptr_r == head_nxt) ? in_data : mem[head_nxt];
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module asp_host_end #(
    parameter int unsigned POWER_DOWN_N_CYC     = asp_pkg::POWER_DOWN_N_CYC,
    parameter int unsigned DSS_FAST_CYC = asp_pkg::DSS_FAST_CYC,
    parameter int unsigned DSS_SLOW_CYC = asp_pkg::DSS_SLOW_CYC
) (
    asp_link_if.host                         link,
    input  wire logic                        clk_sys,
    input  wire logic                        resetn,
    input  wire logic                        pd_req,
    input  wire logic                        stby_req,
    input  wire logic                        rate_fast,
    output logic [asp_pkg::DATA_W-1:0]       out_data,
    output logic                             out_valid,
    input  wire logic                        out_ready,
    output logic                             stby_active,
    output logic                             pd_active
);
    localparam int CW = asp_pkg::CNT_W;
    localparam int DW = asp_pkg::DATA_W;
    localparam int BW = asp_pkg::BIT_W;

    logic                    rdy_m_r;
    logic                    rdy_s_r;
    asp_pkg::asp_hst_state_t state_r;
    asp_pkg::asp_hst_state_t state_nxt;
    logic [CW-1:0]           tcnt_r;
    logic [CW-1:0]           since_r;
    logic [BW-1:0]           bit_r;
    logic [DW-1:0]           cap_r;
    logic                    push_r;
    logic                    sclk_r;
    logic                    pdn_r;
    logic                    fifo_in_ready;
    logic                    half_done;
    logic                    pd_done;
    logic                    dss_ok;
    logic                    stby_held;
    logic                    last_bit;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdy_m_r <= 1'b1;
            rdy_s_r <= 1'b1;
        end else begin
            rdy_m_r <= link.ready_data_out;
            rdy_s_r <= rdy_m_r;
        end
    end

    assign half_done = (tcnt_r == CW'(asp_pkg::SCLK_HALF_CYC - 1));
    // The low time covers both the supply settling and the pulse width.
    assign pd_done   = (tcnt_r >= CW'(POWER_DOWN_N_CYC - 1))
                       && (tcnt_r >= CW'(asp_pkg::PWRUP_CYC - 1)); // R10 R14
    assign dss_ok    = since_r < (rate_fast ? CW'(DSS_FAST_CYC)
                                            : CW'(DSS_SLOW_CYC)); // R4
    assign stby_held = (tcnt_r >= CW'(asp_pkg::STBY_HOLD_CYC - 1)); // R5
    assign last_bit  = (bit_r == BW'(asp_pkg::SCLK_TOTAL - 1));

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_nxt = state_r;
        if (pd_req && state_r != asp_pkg::HST_PD) begin
            state_nxt = asp_pkg::HST_PD; // R13
        end else begin
            unique case (state_r)
                asp_pkg::HST_PD: begin
                    if (pd_done && !pd_req) begin
                        state_nxt = asp_pkg::HST_IDLE; // R14
                    end
                end
                asp_pkg::HST_IDLE: begin
                    if (!rdy_s_r && stby_req && dss_ok) begin
                        state_nxt = asp_pkg::HST_STBY; // R1
                    end else if (!rdy_s_r && fifo_in_ready) begin
                        state_nxt = asp_pkg::HST_HI;
                    end
                end
                asp_pkg::HST_HI: begin
                    if (half_done) begin
                        state_nxt = asp_pkg::HST_LO;
                    end
                end
                asp_pkg::HST_LO: begin
                    if (half_done) begin
                        state_nxt = last_bit ? asp_pkg::HST_IDLE : asp_pkg::HST_HI;
                    end
                end
                asp_pkg::HST_STBY: begin
                    if (stby_held && !stby_req) begin
                        state_nxt = asp_pkg::HST_IDLE; // R7
                    end
                end
                default: begin
                    state_nxt = asp_pkg::HST_PD;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_r <= asp_pkg::HST_PD;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tcnt_r <= '0;
        end else if (state_nxt != state_r) begin
            tcnt_r <= '0;
        end else if (tcnt_r != '1) begin
            tcnt_r <= tcnt_r + CW'(1);
        end
    end

    // Time since the ready fall, used to police the standby window.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            since_r <= '0;
        end else if (rdy_s_r) begin
            since_r <= '0;
        end else if (since_r != '1) begin
            since_r <= since_r + CW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Readback: sample at the end of each of the first 18 low phases, MSB first, and keep
    // clocking to the full count so the line is left high for polling.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bit_r  <= '0;
            cap_r  <= '0;
            push_r <= 1'b0;
        end else begin
            push_r <= (state_r == asp_pkg::HST_LO) && half_done && last_bit;
            if (state_r == asp_pkg::HST_IDLE) begin
                bit_r <= '0;
            end else if (state_r == asp_pkg::HST_LO && half_done) begin
                bit_r <= bit_r + BW'(1);
                if (bit_r < BW'(DW)) begin
                    cap_r <= {cap_r[DW-2:0], rdy_s_r}; // R17
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sclk_r      <= 1'b0;
            pdn_r       <= 1'b0;
            stby_active <= 1'b0;
            pd_active   <= 1'b1;
        end else begin
            sclk_r      <= (state_nxt == asp_pkg::HST_HI)
                           || (state_nxt == asp_pkg::HST_STBY); // R1
            pdn_r       <= (state_nxt != asp_pkg::HST_PD); // R11
            stby_active <= (state_nxt == asp_pkg::HST_STBY);
            pd_active   <= (state_nxt == asp_pkg::HST_PD);
        end
    end

    assign link.sclk         = sclk_r;
    assign link.power_down_n = pdn_r;

    // A full queue holds off the next readback, so results are never dropped
    // here; the device simply overwrites an unread one.
    asp_fifo #(
        .W     (DW),
        .DEPTH (asp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .in_valid  (push_r),
        .in_ready  (fifo_in_ready),
        .in_data   (cap_r),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data)
    );

endmodule

// ---- testbench/asp_link_props.sv ----
module asp_link_props (
    input wire logic clk_link,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic power_down_n,
    input wire logic ready_data_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] hi_r;

    // Saturates so a long standby cannot wrap back into the readback range.
    always_ff @(posedge clk_link or negedge resetn) begin
        if (!resetn) hi_r <= 8'h00;
        else if (!sclk) hi_r <= 8'h00;
        else if (hi_r != 8'hff) hi_r <= hi_r + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_link); endclocking
    default disable iff (!resetn);

    a_stby_line_high: assert property (hi_r > 8'h87 |-> ready_data_out)
        else $error("line low in standby");
    a_stby_min_hold: assert property ($fell(sclk) && hi_r > 8'h14 |-> hi_r >= 8'h78)
        else $error("standby hold too short");
    a_exit_line_quiet: assert property ($fell(sclk) && hi_r > 8'h87 |-> ready_data_out [*8])
        else $error("early ready after standby");
    a_pulse_high_len: assert property ($rose(sclk) |-> sclk [*6])
        else $error("short shift clock high");
    a_pulse_low_len: assert property ($fell(sclk) |-> !sclk [*6])
        else $error("short shift clock low");
    a_bit_steady: assert property ($rose(sclk) && power_down_n
        |=> $stable(ready_data_out) [*2])
        else $error("bit changed too soon");
    a_pd_line_high: assert property (!power_down_n [*4] |-> ready_data_out)
        else $error("line low in power-down");
    a_pd_pulse_min: assert property ($fell(power_down_n) |-> !power_down_n [*8])
        else $error("power-down pulse short");
    a_wake_quiet: assert property ($rose(power_down_n) |-> ready_data_out [*8])
        else $error("ready during wake");

    c_standby: cover property (hi_r > 8'h87);
    c_readback: cover property ($rose(sclk) && !ready_data_out);
    c_power_down: cover property ($fell(power_down_n));
endmodule

// ---- testbench/adc_standby_powerdown_control_test.sv ----
module adc_standby_powerdown_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int EXIT_F = 410;
    localparam int CONV_S = 480;
    logic        clk_sys   = 1'b0;
    logic        clk_link  = 1'b0;
    logic        resetn    = 1'b0;
    logic        pd_req    = 1'b0;
    logic        stby_req  = 1'b0;
    logic        rate_fast = 1'b1;
    logic        out_ready = 1'b0;
    logic [17:0] sample_in = 18'h2a5c3;
    logic [17:0] out_data, d;
    logic        out_valid, stby_active, pd_active, analog_on, converter_on, standby_on;
    int          n_mismatch = 0, total_checks = 0, cyc = 0, n;

    always #2.5 clk_sys = ~clk_sys;
    // The offset keeps the link edges off the system grid.
    initial begin #1.3; forever #80 clk_link = ~clk_link; end

    asp_link_if asp_link_if_inst (.clk_link);
    asp_dev_end #(.CONV_FAST_CYC(400), .CONV_SLOW_CYC(CONV_S), .EXIT_FAST_CYC(EXIT_F),
        .EXIT_SLOW_CYC(520)) asp_dev_end_inst (.link(asp_link_if_inst.dev), .resetn,
        .rate_fast, .sample_in, .analog_on, .converter_on, .standby_on);
    asp_host_end #(.POWER_DOWN_N_CYC(2000), .DSS_FAST_CYC(20000), .DSS_SLOW_CYC(20000))
        asp_host_end_inst (.link(asp_link_if_inst.host), .clk_sys, .resetn, .pd_req,
        .stby_req, .rate_fast, .out_data, .out_valid, .out_ready, .stby_active,
        .pd_active);
    asp_link_props asp_link_props_inst (.clk_link, .resetn, .sclk(asp_link_if_inst.sclk),
        .power_down_n(asp_link_if_inst.power_down_n),
        .ready_data_out(asp_link_if_inst.ready_data_out));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic take();
        @(negedge clk_sys);
        while (out_valid !== 1'b1) @(negedge clk_sys);
        d = out_data;
        out_ready = 1'b1;
        @(negedge clk_sys);
        out_ready = 1'b0;
    endtask

    task automatic link_wait();
        n = 0;
        while (asp_link_if_inst.ready_data_out !== 1'b0) begin
            @(negedge clk_link);
            n++;
        end
    endtask

    task automatic stop_test();
        if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_standby();
        sample_in = 18'h1f00e;
        stby_req = 1'b1;
        wait (standby_on === 1'b1);
        @(negedge clk_sys);
        chk("analog", analog_on, 1'b0);
        chk("osc", converter_on, 1'b1);
        chk("line", asp_link_if_inst.ready_data_out, 1'b1);
        chk("host stby", stby_active, 1'b1);
        repeat (400) @(negedge clk_sys);
        stby_req = 1'b0;
        wait (asp_link_if_inst.sclk === 1'b0);
        link_wait();
        chk("exit time", n >= EXIT_F && n <= EXIT_F + 8, 1'b1);
        take();
        chk("after stby", d, 32'h1f00e);
    endtask

    // Power-down lands five bits into a readback; the cut word must be lost.
    task automatic t_powerdown();
        rate_fast = 1'b0;
        sample_in = 18'h3c0a5;
        wait (asp_link_if_inst.sclk === 1'b1);
        repeat (2000) @(negedge clk_sys);
        pd_req = 1'b1;
        repeat (300) @(negedge clk_sys);
        chk("conv off", converter_on, 1'b0);
        chk("analog pd", analog_on, 1'b0);
        chk("line pd", asp_link_if_inst.ready_data_out, 1'b1);
        chk("host pd", pd_active, 1'b1);
        pd_req = 1'b0;
        wait (asp_link_if_inst.power_down_n === 1'b1);
        link_wait();
        chk("wake time", n >= CONV_S + 50 && n <= CONV_S + 58, 1'b1);
        take();
        chk("after pd", d, 32'h3c0a5);
    endtask

    initial begin
        repeat (2) @(posedge clk_link);
        @(negedge clk_sys);
        resetn = 1'b1;
        // The consumer is idle at first, so the word must wait at the head.
        wait (out_valid === 1'b1);
        repeat (8) @(negedge clk_sys);
        chk("word held", {out_valid, out_data}, {1'b1, 18'h2a5c3});
        take();
        chk("first word", d, 32'h2a5c3);
        t_standby();
        t_powerdown();
        stop_test();
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 120000) begin
            n_mismatch++;
            stop_test();
        end
    end
endmodule
